// ===== common/spis_pkg.sv
package spis_pkg;
   // apb map, byte addresses
   localparam logic [11:0] ADDR_MODE   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [15:0] MODE_RST    = 16'h0000;
   localparam logic [15:0] MODE_MASK   = 16'h00DB;
   // mode register fields
   localparam int F_MUX_LO = 0;
   localparam int F_JOIN2  = 3;
   localparam int F_JOIN3  = 4;
   localparam int F_GRP_LO = 6;
   // status register fields
   localparam int S_MEMB_LO = 0;
   localparam int S_SYNC    = 3;
   localparam int S_OWN_LO  = 4;
   localparam int NCH       = 3;
   // isdn frame: first bearer, second bearer, signalling pair
   localparam logic [7:0] ISDN_B1_END = 8'h08;
   localparam logic [7:0] ISDN_B2_END = 8'h10;
   localparam logic [7:0] ISDN_D_END  = 8'h12;
   localparam logic [7:0] SLOT_BITS   = 8'h08;
   localparam logic [1:0] OWN_NONE    = 2'h3;
   // pin idle levels {transmit_clock, rclk, rxd, cts_n, cd_n}: clocks low, the rest high
   localparam logic [4:0] PIN_IDLE    = 5'h07;
   typedef enum logic [1:0]
   {
      SPIS_NONMUX = 2'b00,
      SPIS_PCM    = 2'b01,
      SPIS_ICL    = 2'b10,
      SPIS_CCL    = 2'b11
   } spis_mode_t;
   // outer pins of one channel, inputs
   typedef struct packed {
      logic transmit_clock;
      logic rclk;
      logic rxd;
      logic cts_n;
      logic cd_n;
   } spis_pin_in_t;
   typedef struct packed {
      logic txd;
      logic rts_n;
   } spis_pin_out_t;
   // what a serial channel hands to the mux
   typedef struct packed {
      logic txd;
      logic rts_n;
   } spis_chan_out_t;
   // what the mux hands to a serial channel
   typedef struct packed {
      logic rxd;
      logic rx_stb;
      logic tx_stb;
      logic cts_n;
      logic cd_n;
   } spis_chan_in_t;
endpackage

// ===== logic/spis_top.sv
`timescale 1ns/1ps
`default_nettype none
module spis_top
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_ce,
   input  wire logic                   i_psel,
   input  wire logic                   i_penable,
   input  wire logic                   i_pwrite,
   input  wire logic [11:0]            i_paddr,
   input  wire logic [31:0]            i_pwdata,
   input  wire logic [3:0]             i_pstrb,
   output logic      [31:0]            o_prdata,
   output logic                        o_pready,
   output logic                        o_pslverr,
   input  wire spis_pkg::spis_pin_in_t  i_pin   [3],
   output spis_pkg::spis_pin_out_t      o_pin   [3],
   input  wire spis_pkg::spis_chan_out_t i_chan [3],
   output spis_pkg::spis_chan_in_t      o_chan  [3]
);
   // pin synchronisers, s1 feeds only s2
   spis_pkg::spis_pin_in_t s1_r [3];
   spis_pkg::spis_pin_in_t s2_r [3];
   spis_pkg::spis_pin_in_t s3_r [3];
   logic [2:0] transmit_clock_fall, rclk_rise, rclk_fall;
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge i_core_clk)
         begin
            if (!i_rst_n)
            begin
               // stages start at the idle levels, so no false edge follows reset
               s1_r[g] <= spis_pkg::spis_pin_in_t'(spis_pkg::PIN_IDLE);
               s2_r[g] <= spis_pkg::spis_pin_in_t'(spis_pkg::PIN_IDLE);
               s3_r[g] <= spis_pkg::spis_pin_in_t'(spis_pkg::PIN_IDLE);
            end
            else if (i_ce)
            begin
               s1_r[g] <= i_pin[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
            end
         end
         // edges found from the second and third stage only
         assign transmit_clock_fall[g] = s3_r[g].transmit_clock & ~s2_r[g].transmit_clock;
         assign rclk_rise[g] = ~s3_r[g].rclk & s2_r[g].rclk;
         assign rclk_fall[g] = s3_r[g].rclk & ~s2_r[g].rclk;
      end
   endgenerate

   // mode register and apb response
   logic [15:0] mode_r, mode_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        err_r, err_nxt;
   logic        hit_mode, hit_stat, wr_go;
   logic [31:0] status;
   spis_pkg::spis_mode_t mux;
   logic [2:0]  memb;
   logic [1:0]  grp;

   assign mux  = spis_pkg::spis_mode_t'(mode_r[spis_pkg::F_MUX_LO +: 2]);
   assign grp  = mode_r[spis_pkg::F_GRP_LO +: 2];
   // joins are void without a mux type, so at most one grouping exists
   assign memb[0] = (mux != spis_pkg::SPIS_NONMUX);
   assign memb[1] = memb[0] & mode_r[spis_pkg::F_JOIN2];
   assign memb[2] = memb[0] & mode_r[spis_pkg::F_JOIN3];

   assign hit_mode = (i_paddr == spis_pkg::ADDR_MODE);
   assign hit_stat = (i_paddr == spis_pkg::ADDR_STATUS);
   assign wr_go    = i_psel & i_penable & i_pwrite & hit_mode;
   assign o_pready = i_psel & i_penable;

   // read data and error latched in the setup cycle
   always_comb
   begin
      mode_nxt  = mode_r;
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      if (wr_go)
      begin
         if (i_pstrb[0])
            mode_nxt[7:0] = i_pwdata[7:0] & spis_pkg::MODE_MASK[7:0];
         if (i_pstrb[1])
            mode_nxt[15:8] = i_pwdata[15:8] & spis_pkg::MODE_MASK[15:8];
      end
      if (i_psel & ~i_penable)
      begin
         err_nxt   = ~(hit_mode | hit_stat);
         rdata_nxt = hit_mode ? {16'h0000, mode_r} : (hit_stat ? status : 32'h0000_0000);
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         mode_r  <= spis_pkg::MODE_RST;
         rdata_r <= 32'h0000_0000;
         err_r   <= 1'b0;
      end
      else if (i_ce)
      begin
         mode_r  <= mode_nxt;
         rdata_r <= rdata_nxt;
         err_r   <= err_nxt;
      end
   end
   assign o_prdata  = rdata_r;
   assign o_pslverr = err_r & o_pready;

   // shared frame: layer-one clock on chan one rclk pin, sync on its cd pin
   logic       l1_rise, l1_fall, sync_on;
   logic [7:0] bit_r, bit_nxt;
   logic [1:0] own;
   assign l1_rise = rclk_rise[0];
   assign l1_fall = rclk_fall[0];
   assign sync_on = memb[0] & ~s2_r[0].cd_n;

   // slot owner of the current bit position, OWN_NONE when idle
   function automatic logic [1:0] owner_f
   (
      input logic [7:0]           pos,
      input spis_pkg::spis_mode_t md,
      input logic [2:0]           mb,
      input logic [1:0]           gr
   );
      logic [9:0] w;
      logic [1:0] k;
      logic [1:0] r;
      // widen before adding one, a group of four slots must not wrap to zero
      w = {2'b00, spis_pkg::SLOT_BITS} * ({8'h00, gr} + 10'h001);
      k = 2'h3;
      r = spis_pkg::OWN_NONE;
      if (md == spis_pkg::SPIS_PCM)
      begin
         // group of slots per member, members in channel order
         if ({2'b00, pos} < w)
            k = 2'h0;
         else if ({2'b00, pos} < 10'(2 * w))
            k = 2'h1;
         else if ({2'b00, pos} < 10'(3 * w))
            k = 2'h2;
         unique case (k)
            2'h0: r = 2'h0;
            2'h1: r = mb[1] ? 2'h1 : (mb[2] ? 2'h2 : spis_pkg::OWN_NONE);
            2'h2: r = (mb[1] & mb[2]) ? 2'h2 : spis_pkg::OWN_NONE;
            2'h3: r = spis_pkg::OWN_NONE;
         endcase
      end
      else if (md != spis_pkg::SPIS_NONMUX)
      begin
         // isdn: first bearer, second bearer, signalling bits
         if (pos < spis_pkg::ISDN_B1_END)
            r = 2'h0;
         else if (pos < spis_pkg::ISDN_B2_END)
            r = mb[1] ? 2'h1 : spis_pkg::OWN_NONE;
         else if (pos < spis_pkg::ISDN_D_END)
            r = mb[2] ? 2'h2 : spis_pkg::OWN_NONE;
      end
      return r;
   endfunction

   assign own = sync_on ? owner_f(bit_r, mux, memb, grp) : spis_pkg::OWN_NONE;

   // bit position counts from sync start, saturates on long frames
   always_comb
   begin
      bit_nxt = bit_r;
      if (!sync_on)
         bit_nxt = 8'h00;
      else if (l1_fall && bit_r != 8'hFF)
         bit_nxt = bit_r + 8'h01;
   end

   // per channel strobes and pin data
   logic [2:0] rx_stb_nxt, tx_stb_nxt, rxd_nxt, txd_nxt, rts_nxt;
   logic [2:0] rx_stb_r, tx_stb_r, rxd_r, txd_r, rts_r;
   logic       mux_txd_nxt, mux_txd_r;

   always_comb
   begin
      rx_stb_nxt  = 3'b000;
      tx_stb_nxt  = 3'b000;
      rxd_nxt     = rxd_r;
      txd_nxt     = txd_r;
      rts_nxt     = rts_r;
      mux_txd_nxt = mux_txd_r;
      for (int i = 0; i < spis_pkg::NCH; i++)
      begin
         if (!memb[i])
         begin
            // own port: launch on transmit_clock fall, sample on rclk rise
            rts_nxt[i] = i_chan[i].rts_n;
            if (transmit_clock_fall[i])
            begin
               tx_stb_nxt[i] = 1'b1;
               txd_nxt[i]    = i_chan[i].txd;
            end
            if (rclk_rise[i])
            begin
               rx_stb_nxt[i] = 1'b1;
               rxd_nxt[i]    = s2_r[i].rxd;
            end
         end
         else
         begin
            // port functions idle while serving the shared frame
            rts_nxt[i] = 1'b1;
            txd_nxt[i] = 1'b1;
            if (own == 2'(i) && l1_rise)
               tx_stb_nxt[i] = 1'b1;
            if (own == 2'(i) && l1_fall)
            begin
               rx_stb_nxt[i] = 1'b1;
               rxd_nxt[i]    = s2_r[0].rxd;
            end
         end
      end
      // idle slots send ones
      if (l1_rise)
         mux_txd_nxt = (own == spis_pkg::OWN_NONE) ? 1'b1 : i_chan[own].txd;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         bit_r     <= 8'h00;
         rx_stb_r  <= 3'b000;
         tx_stb_r  <= 3'b000;
         rxd_r     <= 3'b111;
         txd_r     <= 3'b111;
         rts_r     <= 3'b111;
         mux_txd_r <= 1'b1;
      end
      else if (i_ce)
      begin
         bit_r     <= bit_nxt;
         rx_stb_r  <= rx_stb_nxt;
         tx_stb_r  <= tx_stb_nxt;
         rxd_r     <= rxd_nxt;
         txd_r     <= txd_nxt;
         rts_r     <= rts_nxt;
         mux_txd_r <= mux_txd_nxt;
      end
   end

   assign status = {24'h000000, 2'b00, own, sync_on, memb};

   // outputs: chan one txd pin carries the shared frame in mux mode
   generate
      for (g = 0; g < 3; g++)
      begin : g_out
         assign o_pin[g].txd    = (g == 0 && memb[0]) ? mux_txd_r : txd_r[g];
         assign o_pin[g].rts_n  = rts_r[g];
         assign o_chan[g].rxd    = rxd_r[g];
         assign o_chan[g].rx_stb = rx_stb_r[g] & i_ce;
         assign o_chan[g].tx_stb = tx_stb_r[g] & i_ce;
         // members see clear-to-send, carrier follows sync
         assign o_chan[g].cts_n  = memb[g] ? 1'b0 : s2_r[g].cts_n;
         assign o_chan[g].cd_n   = memb[g] ? ~sync_on : s2_r[g].cd_n;
      end
   endgenerate

   a_mode_reset: assert property (@(posedge i_core_clk)
      $rose(i_rst_n) |-> mode_r == spis_pkg::MODE_RST)
      else $error("mode not default after reset");
   a_write_takes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_go && i_ce && i_pstrb[0]) |=>
         mode_r[7:0] == ($past(i_pwdata[7:0]) & spis_pkg::MODE_MASK[7:0]))
      else $error("mode write lost");
   a_join_void: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (mux == spis_pkg::SPIS_NONMUX) |-> memb == 3'b000)
      else $error("join without mux type");
   a_rts_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (memb[0] && $past(memb[0]) && $past(i_ce)) |-> o_pin[0].rts_n)
      else $error("rts driven in mux mode");
   a_no_sync_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (memb[0] && !$past(sync_on) && $past(memb[0])) |-> !rx_stb_r[0])
      else $error("strobe without sync");
   a_one_owner: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $onehot0(rx_stb_r & {memb[2], memb[1], memb[0]}))
      else $error("two channels own one bit");
   a_port_rx: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !memb[1] && !mode_nxt[spis_pkg::F_JOIN2] && rclk_rise[1]) |=> rx_stb_r[1])
      else $error("nonmux sample missed");
   a_isdn_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (sync_on && mux[1] && bit_r < spis_pkg::ISDN_B1_END) |-> own == 2'h0)
      else $error("first bearer not channel one");
   a_apb_err: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (i_psel && !i_penable && i_ce && !hit_mode && !hit_stat) |=> err_r)
      else $error("unmapped address not flagged");
endmodule
`default_nettype wire

// ===== tb/spis_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module spis_link_model
(
   output spis_pkg::spis_pin_in_t o_pin [3]
);
   localparam int NA_BITS = 24 * 8;
   localparam int EU_BITS = 32 * 8;
   logic lclk   = 1'h0;
   logic sync_n = 1'h1;
   logic dat    = 1'h1;
   // one link clock feeds every port; clear-to-send held asserted
   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         o_pin[k] = '{lclk, lclk, dat, 1'h0, sync_n};
      end
   end
   // clock runs only inside a frame, with sync low around it
   task automatic frame(input int nbits);
      sync_n = 1'h0;
      #43;
      for (int b = 0; b < nbits; b++)
      begin
         #32 lclk = 1'h1;
         dat = ~dat;
         #32 lclk = 1'h0;
      end
      #45 sync_n = 1'h1;
      dat = ~dat; // released line must not look held
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                     clk   = 1'h0;
   logic                     rst_n = 1'h0;
   logic                     psel  = 1'h0;
   logic                     pen   = 1'h0;
   logic                     pwr   = 1'h0;
   logic [11:0]              padr  = 12'h000;
   logic [31:0]              pwd   = 32'h0;
   logic [3:0]               strb  = 4'hF;
   logic [31:0]              prd;
   logic                     prdy;
   logic                     perr;
   logic                     clr   = 1'h0;
   spis_pkg::spis_pin_in_t   pin   [3];
   spis_pkg::spis_pin_out_t  pout  [3];
   spis_pkg::spis_chan_out_t chi   [3] = '{2'h0, 2'h2, 2'h0};
   spis_pkg::spis_chan_in_t  cho   [3];
   int                       txc   [3];
   int                       rxc   [3];
   int                       n_mismatch = 0;
   int                       num_checks = 0;
   logic [31:0]              q;
   logic                     e;
   initial
   begin
      forever #4 clk = ~clk;
   end
   spis_top dut
   (
      .i_core_clk (clk),
      .i_rst_n    (rst_n),
      .i_ce       (1'h1),
      .i_psel     (psel),
      .i_penable  (pen),
      .i_pwrite   (pwr),
      .i_paddr    (padr),
      .i_pwdata   (pwd),
      .i_pstrb    (strb),
      .o_prdata   (prd),
      .o_pready   (prdy),
      .o_pslverr  (perr),
      .i_pin      (pin),
      .o_pin      (pout),
      .i_chan     (chi),
      .o_chan     (cho)
   );
   spis_link_model link
   (
      .o_pin (pin)
   );
   // strobe tallies per channel, cleared between frames
   always @(posedge clk)
   begin
      for (int k = 0; k < 3; k++)
      begin
         txc[k] <= clr ? 0 : txc[k] + int'(cho[k].tx_stb === 1'h1);
         rxc[k] <= clr ? 0 : rxc[k] + int'(cho[k].rx_stb === 1'h1);
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
      num_checks++;
      if (s !== x)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, s, x);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one transfer; request held until pready is seen, then an idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'h1;
      pwr  <= w;
      padr <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'h1 && n < 64);
      q = prd;
      e = perr;
      psel <= 1'h0;
      pen  <= 1'h0;
      if (n >= 64)
      begin
         n_mismatch++;
         wrap_up();
      end
      else
         @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
      apb(1'h0, a, 32'h0);
      chk(q, x, m);
   endtask
   // mode set while the link is idle; strobes counted over one frame
   task automatic run(input logic [15:0] md, input int nb, input int x [3]);
      apb(1'h1, spis_pkg::ADDR_MODE, {16'h0, md});
      clr <= 1'h1;
      @(posedge clk);
      clr <= 1'h0;
      repeat (20) @(posedge clk);
      chk(txc[0] + rxc[0], 0, "strobe with clock stopped");
      link.frame(nb);
      repeat (13) @(posedge clk);
      for (int k = 0; k < 3; k++)
      begin
         chk(txc[k], x[k], "tx strobes");
         chk(rxc[k], x[k], "rx strobes");
      end
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rd(spis_pkg::ADDR_MODE, 32'h0, "mode reset");
      rd(spis_pkg::ADDR_STATUS, 32'h30, "status reset");
      rd(12'h008, 32'h0, "unmapped read");
      chk(32'(e), 32'h1, "unmapped error");
      for (int t = 0; t < 4; t++)
      begin
         apb(1'h1, spis_pkg::ADDR_MODE, 32'h18 | t);
         rd(spis_pkg::ADDR_MODE, 32'h18 | t, "mode type");
      end
      apb(1'h1, spis_pkg::ADDR_MODE, 32'h18);
      rd(spis_pkg::ADDR_STATUS, 32'h30, "joins without mux");
      strb <= 4'h1;
      apb(1'h1, spis_pkg::ADDR_MODE, 32'hFFFF);
      strb <= 4'hF;
      rd(spis_pkg::ADDR_MODE, 32'hDB, "reserved bits");
      apb(1'h1, spis_pkg::ADDR_MODE, 32'h9);
      rd(spis_pkg::ADDR_MODE, 32'h9, "pcm mode");
      rd(spis_pkg::ADDR_STATUS, 32'h33, "pcm members");
      apb(1'h1, 12'h008, 32'h0);
      apb(1'h1, spis_pkg::ADDR_STATUS, 32'h0);
      rd(spis_pkg::ADDR_MODE, 32'h9, "refused writes");
      run(16'h0000, 16, '{16, 16, 16});
      chk(32'(pout[2].txd), 32'h0, "port three txd");
      chk(32'(pout[1].txd), 32'h1, "port two txd");
      chk(32'(pout[2].rts_n), 32'h0, "port three rts");
      run(16'h0009, link.NA_BITS, '{8, 8, link.NA_BITS});
      run(16'h0011, link.NA_BITS, '{8, link.NA_BITS, 8});
      run(16'h0059, link.EU_BITS, '{16, 16, 16});
      chk(32'(pout[0].txd), 32'h1, "idle past owned slots");
      run(16'h001A, link.NA_BITS, '{8, 8, 2});
      run(16'h001B, link.NA_BITS, '{8, 8, 2});
      wrap_up();
   end
endmodule
`default_nettype wire
